/* File: hw/pmc_top.sv */
// phy mode control: registers, straps, negotiation, crossover, isolate
// ----------------------------------------------------------------------
// How it works
// - autoneg negotiates, else parallel detect half duplex
// - pick highest common advertised protocol
// - duplex strap sets advertisement bits 8:5
// - strap 0 limits to half duplex
// - reset with autoneg on, 100 advertised
// - both auto-crossover: random algorithm decides swap
// - auto-crossover default on; strap, control_one, phy_control
// - phy_control bit 14 forces crossover
// - basic_mode_control bit 10 isolates MAC
// - isolate ignores tx, floats MAC outputs
// - management access continues while isolated
// - isolated media keeps sending idles/pulses
// - isolated device still negotiates and links
// - latch 5-bit station address at reset
// - unstrapped station address equals 1
// - indicator mode: 1 link only, 0 blink
// - indicator_control 10:9 set blink rate
// - loopback from basic_mode_control 14, selftest 3:0
// - mac loopback: no link, data returned
// - external loopback uses normal mode
// - crossover strap low disables auto-crossover
// - indicator strap defaults mode 1, writable
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module pmc_top
	import pmc_pkg::*;
#(
	parameter int HALF_CYC = BLINK_HALF_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic        clkEn,
	// management register port
	input  wire logic [4:0]  mgmtPhyAddr,
	input  wire logic [4:0]  mgmtRegAddr,
	input  wire logic        mgmtWrite,
	input  wire logic        mgmtRead,
	input  wire logic [15:0] mgmtWrData,
	output logic [15:0]      mgmtRdData,
	output logic             mgmtRdValid,
	// straps, sampled on the first enabled edge after reset release
	input  wire logic        duplexStrap,
	input  wire logic        autoCrossoverStrap,
	input  wire logic        indicatorModeSelect,
	input  wire logic [4:0]  stationAddressStraps,
	// media side status
	input  wire logic        partnerCanNeg,
	input  wire logic [3:0]  partnerAbil,
	input  wire logic        partnerAutoX,
	input  wire logic        detSpeed100,
	input  wire logic        mediaLinkUp,
	input  wire logic        randomBit,
	input  wire logic        activity,
	// MAC side gating
	input  wire logic        macTxEn,
	output logic             macTxAccept,
	output logic             macOutEn,
	output logic             mediaSendData,
	output logic             mediaSendIdle,
	output logic             loopMac,
	output logic [3:0]       loopSel,
	output logic             linkReported,
	output logic             crossover,
	output logic             speed100,
	output logic             fullDuplex,
	output logic             linkIndicatorOutput,
	output logic [4:0]       stationAddr
);
	initial begin
		if (HALF_CYC < 4) $error("pmc_top: HALF_CYC too small");
	end

	// ------------------------------------------------------------------
	// register state
	// ------------------------------------------------------------------
	logic [15:0] bmc_r, bmc_nxt;
	logic [15:0] adv_r, adv_nxt;
	logic [15:0] ctl1_r, ctl1_nxt;
	logic [15:0] stl_r, stl_nxt;
	logic [15:0] ind_r, ind_nxt;
	logic [15:0] phc_r, phc_nxt;
	logic [4:0]  addr_r, addr_nxt;
	logic        dupStrap_r, dupStrap_nxt;
	logic        strapPend_r, strapPend_nxt;
	logic [15:0] rd_r, rd_nxt;
	logic        rdv_r, rdv_nxt;
	logic        hit;

	// straps caught on the first enabled edge after reset release
	always_comb begin
		bmc_nxt       = bmc_r;
		adv_nxt       = adv_r;
		ctl1_nxt      = ctl1_r;
		stl_nxt       = stl_r;
		ind_nxt       = ind_r;
		phc_nxt       = phc_r;
		addr_nxt      = addr_r;
		dupStrap_nxt  = dupStrap_r;
		strapPend_nxt = 1'b0;
		rd_nxt        = rd_r;
		rdv_nxt       = 1'b0;
		hit           = (mgmtPhyAddr == addr_r) && !strapPend_r;
		if (strapPend_r) begin
			addr_nxt     = stationAddressStraps;
			dupStrap_nxt = duplexStrap;
			adv_nxt[ADV_ABIL_HI:ADV_ABIL_LO] =
				duplexStrap ? ADV_FULL : ADV_HALF;
			ctl1_nxt[CTL1_AUTOX_BIT] = autoCrossoverStrap;
			phc_nxt[PHC_AUTOX_BIT]   = autoCrossoverStrap;
			phc_nxt[PHC_INDMODE_BIT] = indicatorModeSelect;
		end else if (hit && mgmtWrite) begin
			unique case (mgmtRegAddr)
				REG_BASIC_MODE_CONTROL:    bmc_nxt = mgmtWrData;
				REG_AUTONEG_ADVERTISEMENT: adv_nxt = mgmtWrData;
				REG_CONTROL_ONE:           ctl1_nxt = mgmtWrData;
				REG_SELFTEST_LOOP_CONTROL: stl_nxt = mgmtWrData;
				REG_INDICATOR_CONTROL:     ind_nxt = mgmtWrData;
				REG_PHY_CONTROL:           phc_nxt = mgmtWrData;
				default:                   ;
			endcase
		end
		if (hit && mgmtRead) begin
			rdv_nxt = 1'b1;
			unique case (mgmtRegAddr)
				REG_BASIC_MODE_CONTROL:    rd_nxt = bmc_r;
				REG_AUTONEG_ADVERTISEMENT: rd_nxt = adv_r;
				REG_CONTROL_ONE:           rd_nxt = ctl1_r;
				REG_SELFTEST_LOOP_CONTROL: rd_nxt = stl_r;
				REG_INDICATOR_CONTROL:     rd_nxt = ind_r;
				REG_PHY_CONTROL:           rd_nxt = phc_r;
				default:                   rd_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			bmc_r       <= BMC_RESET;
			adv_r       <= ADV_BASE | {7'h00, ADV_FULL, 5'h00};
			ctl1_r      <= CTL1_RESET;
			stl_r       <= 16'h0000;
			ind_r       <= {5'h00, RATE_5HZ, 9'h000};
			phc_r       <= PHC_RESET;
			addr_r      <= ADDR_DFLT;
			dupStrap_r  <= 1'b1;
			strapPend_r <= 1'b1;
			rd_r        <= 16'h0000;
			rdv_r       <= 1'b0;
		end else if (clkEn) begin
			bmc_r       <= bmc_nxt;
			adv_r       <= adv_nxt;
			ctl1_r      <= ctl1_nxt;
			stl_r       <= stl_nxt;
			ind_r       <= ind_nxt;
			phc_r       <= phc_nxt;
			addr_r      <= addr_nxt;
			dupStrap_r  <= dupStrap_nxt;
			strapPend_r <= strapPend_nxt;
			rd_r        <= rd_nxt;
			rdv_r       <= rdv_nxt;
		end
	end

	assign mgmtRdData  = rd_r;
	assign mgmtRdValid = rdv_r;
	assign stationAddr = addr_r;

	// ------------------------------------------------------------------
	// mode resolution
	// ------------------------------------------------------------------
	logic [3:0] localAbil;
	logic       anyCommon;
	pmc_mode_e  best;

	always_comb begin
		localAbil = adv_r[ADV_ABIL_HI:ADV_ABIL_LO];
		if (!dupStrap_r) begin
			localAbil = localAbil & ADV_HALF;
		end
	end

	pmc_resolve u_resolve (
		.localAbil   (localAbil),
		.partnerAbil (partnerAbil),
		.anyCommon   (anyCommon),
		.bestMode    (best)
	);

	logic        spd_r, spd_nxt;
	logic        fdx_r, fdx_nxt;
	logic        xov_r, xov_nxt;
	logic        mLoop, autoX, neg;
	logic        blinkPhase;

	always_comb begin
		mLoop   = bmc_r[BMC_LOOP_BIT];
		neg     = bmc_r[BMC_AUTONEG_BIT];
		autoX   = phc_r[PHC_AUTOX_BIT] & ctl1_r[CTL1_AUTOX_BIT];
		spd_nxt = bmc_r[BMC_SPEED_BIT];
		fdx_nxt = bmc_r[BMC_DUPLEX_BIT] & dupStrap_r;
		// negotiation keeps running while isolated
		if (neg && partnerCanNeg && anyCommon) begin
			spd_nxt = (best == SPD_100F) || (best == SPD_100H);
			fdx_nxt = (best == SPD_100F) || (best == SPD_10F);
		end else if (neg) begin
			spd_nxt = detSpeed100;
			fdx_nxt = 1'b0;
		end
		xov_nxt = xov_r;
		if (phc_r[PHC_FORCEX_BIT]) begin
			xov_nxt = 1'b1;
		end else if (autoX && !mediaLinkUp) begin
			// both sides hunting: random choice; else we swap alone
			xov_nxt = partnerAutoX ? randomBit : ~xov_r;
		end else if (!autoX) begin
			xov_nxt = 1'b0;
		end
		// straps not latched yet: hold reset modes, no early full duplex
		if (strapPend_r) begin
			spd_nxt = spd_r;
			fdx_nxt = fdx_r;
			xov_nxt = xov_r;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			spd_r <= 1'b1;
			fdx_r <= 1'b0;
			xov_r <= 1'b0;
		end else if (clkEn) begin
			spd_r <= spd_nxt;
			fdx_r <= fdx_nxt;
			xov_r <= xov_nxt;
		end
	end

	assign speed100   = spd_r;
	assign fullDuplex = fdx_r;
	assign crossover  = xov_r;

	// ------------------------------------------------------------------
	// isolate, loopback and indicator
	// ------------------------------------------------------------------
	pmc_blink #(
		.HALF_CYC (HALF_CYC)
	) u_blink (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.clkEn   (clkEn),
		.rateSel (ind_r[IND_RATE_HI:IND_RATE_LO]),
		.phase   (blinkPhase)
	);

	logic iso;
	logic ind_r2, ind_nxt2;

	always_comb begin
		iso         = bmc_r[BMC_ISOLATE_BIT];
		macTxAccept = macTxEn & ~iso;
		macOutEn    = ~iso;
		// media sends data only when not isolated; idles always
		mediaSendData = macTxEn & ~iso & (~mLoop |
			(spd_r & stl_r[STL_TXMEDIA_BIT]));
		mediaSendIdle = 1'b1;
		loopMac      = mLoop;
		loopSel      = stl_r[3:0];
		linkReported = mediaLinkUp & ~mLoop;
		if (phc_r[PHC_INDMODE_BIT]) begin
			ind_nxt2 = linkReported;
		end else begin
			ind_nxt2 = linkReported & ~(activity & blinkPhase);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			ind_r2 <= 1'b0;
		end else if (clkEn) begin
			ind_r2 <= ind_nxt2;
		end
	end

	assign linkIndicatorOutput = ind_r2;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	a_strap_addr_latch: assert property (
		$past(strapPend_r) && $past(clkEn) && $past(rst_b) |->
			addr_r == $past(stationAddressStraps))
		else $error("station address not latched");
	a_strap_half_adv: assert property (
		$past(strapPend_r) && $past(clkEn) && $past(rst_b) &&
			!$past(duplexStrap) |->
			adv_r[8:5] == 4'h5)
		else $error("half duplex strap not advertised");
	a_strap_half_only: assert property (
		!dupStrap_r && !strapPend_r |=> !fdx_r || !$past(clkEn))
		else $error("full duplex with half strap");
	a_pardet_half: assert property (
		clkEn && neg && !partnerCanNeg |=> !fdx_r)
		else $error("parallel detect not half duplex");
	a_force_cross: assert property (
		clkEn && phc_r[14] |=> xov_r)
		else $error("forced crossover ignored");
	a_isolate_gates: assert property (
		iso |-> !macOutEn && !macTxAccept && !mediaSendData)
		else $error("isolate not applied");
	a_loop_nolink: assert property (
		clkEn && mLoop |=> !linkIndicatorOutput)
		else $error("link shown in mac loopback");
	a_read_answer: assert property (
		clkEn && mgmtRead && mgmtPhyAddr == addr_r && !strapPend_r
			|=> mgmtRdValid)
		else $error("management read not answered");

	c_isolate:  cover property (iso && mgmtRdValid);
	c_negfull:  cover property (fdx_r && spd_r);
	c_loop:     cover property (mLoop && mediaSendData);
	c_blink:    cover property (activity && blinkPhase && linkReported);
endmodule : pmc_top
`default_nettype wire

/* File: hw/pmc_pkg.sv */
// package: register map, fields, reset values and timing for phy mode control
package pmc_pkg;

	// ------------------------------------------------------------------
	// register offsets (management register addresses)
	// ------------------------------------------------------------------
	localparam logic [4:0] REG_BASIC_MODE_CONTROL   = 5'h00;
	localparam logic [4:0] REG_AUTONEG_ADVERTISEMENT = 5'h04;
	localparam logic [4:0] REG_CONTROL_ONE          = 5'h09;
	localparam logic [4:0] REG_SELFTEST_LOOP_CONTROL = 5'h16;
	localparam logic [4:0] REG_INDICATOR_CONTROL    = 5'h18;
	localparam logic [4:0] REG_PHY_CONTROL          = 5'h19;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int BMC_LOOP_BIT     = 14;
	localparam int BMC_AUTONEG_BIT  = 12;
	localparam int BMC_ISOLATE_BIT  = 10;
	localparam int BMC_SPEED_BIT    = 13;
	localparam int BMC_DUPLEX_BIT   = 8;
	localparam int ADV_ABIL_LO      = 5;
	localparam int ADV_ABIL_HI      = 8;
	localparam int CTL1_AUTOX_BIT   = 14;
	localparam int STL_TXMEDIA_BIT  = 6;
	localparam int IND_RATE_LO      = 9;
	localparam int IND_RATE_HI      = 10;
	localparam int PHC_AUTOX_BIT    = 15;
	localparam int PHC_FORCEX_BIT   = 14;
	localparam int PHC_INDMODE_BIT  = 5;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [15:0] BMC_RESET  = 16'h3000;
	localparam logic [15:0] CTL1_RESET = 16'h4000;
	localparam logic [15:0] PHC_RESET  = 16'h8020;
	localparam logic [15:0] ADV_BASE   = 16'h0001;
	localparam logic [3:0]  ADV_FULL   = 4'hf;
	localparam logic [3:0]  ADV_HALF   = 4'h5;
	localparam logic [1:0]  RATE_5HZ   = 2'h0;
	localparam logic [4:0]  ADDR_DFLT  = 5'h01;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int CLK_HZ         = 40000000;
	localparam int BLINK_5HZ      = 5;
	localparam int BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_5HZ);

	// resolved link modes
	typedef enum logic [3:0] {
		SPD_10H  = 4'b0001,
		SPD_10F  = 4'b0010,
		SPD_100H = 4'b0100,
		SPD_100F = 4'b1000
	} pmc_mode_e;

endpackage : pmc_pkg

/* File: hw/pmc_resolve.sv */
// priority resolution of the common link mode
`timescale 1ns/1ps
`default_nettype none
module pmc_resolve
	import pmc_pkg::*;
(
	input  wire logic [3:0] localAbil,
	input  wire logic [3:0] partnerAbil,
	output logic            anyCommon,
	output pmc_mode_e       bestMode
);
	logic [3:0] common;

	// ability bits: [0]10H [1]10F [2]100H [3]100F, highest wins
	always_comb begin
		common    = localAbil & partnerAbil;
		anyCommon = |common;
		if (common[3]) begin
			bestMode = SPD_100F;
		end else if (common[2]) begin
			bestMode = SPD_100H;
		end else if (common[1]) begin
			bestMode = SPD_10F;
		end else begin
			bestMode = SPD_10H;
		end
	end
endmodule : pmc_resolve
`default_nettype wire

/* File: hw/pmc_blink.sv */
// activity blink timebase for the indicator output
`timescale 1ns/1ps
`default_nettype none
module pmc_blink
	import pmc_pkg::*;
#(
	parameter int HALF_CYC = BLINK_HALF_CYC
) (
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	input  wire logic       clkEn,
	input  wire logic [1:0] rateSel,
	output logic            phase
);
	initial begin
		if (HALF_CYC < 4) $error("pmc_blink: HALF_CYC too small");
	end

	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic        phase_r;
	logic        phase_nxt;
	logic [31:0] limit;

	// rate 0 = 5 Hz; higher codes run 2x, 4x, 8x faster
	always_comb begin
		limit     = 32'(HALF_CYC) >> rateSel;
		cnt_nxt   = cnt_r + 32'h1;
		phase_nxt = phase_r;
		if (cnt_r + 32'h1 >= limit) begin
			cnt_nxt   = 32'h0;
			phase_nxt = ~phase_r;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cnt_r   <= 32'h0;
			phase_r <= 1'b0;
		end else if (clkEn) begin
			cnt_r   <= cnt_nxt;
			phase_r <= phase_nxt;
		end
	end

	assign phase = phase_r;
endmodule : pmc_blink
`default_nettype wire

/* File: verification/pmc_link_partner.sv */
// link partner model: media-side status seen by the mode control block
`timescale 1ns/1ps
`default_nettype none
module pmc_link_partner (
	input  wire logic       ref_clk,
	input  wire logic       negOn,
	input  wire logic [3:0] abilSet,
	input  wire logic       autoXOn,
	input  wire logic       linkOn,
	input  wire logic       fastOn,
	input  wire logic       busyOn,
	output logic            partnerCanNeg,
	output logic [3:0]      partnerAbil,
	output logic            partnerAutoX,
	output logic            detSpeed100,
	output logic            mediaLinkUp,
	output logic            randomBit,
	output logic            activity
);
	logic [7:0] lfsr;

	initial begin
		lfsr = 8'h5a;
		{partnerCanNeg, partnerAbil, partnerAutoX} = 6'h00;
		{detSpeed100, mediaLinkUp, randomBit, activity} = 4'h0;
	end

	// status changes just after the edge, like any real driver
	always @(posedge ref_clk) begin
		#2;
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		randomBit = lfsr[0];
		partnerCanNeg = negOn;
		// a partner that cannot negotiate advertises nothing
		partnerAbil = negOn ? abilSet : 4'h0;
		partnerAutoX = autoXOn;
		detSpeed100 = fastOn;
		mediaLinkUp = linkOn;
		activity = busyOn;
	end
endmodule : pmc_link_partner
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the phy mode control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import pmc_pkg::*;
	logic        ref_clk = 0, rst_b = 0, clkEn = 1, macTxEn = 0;
	logic [4:0]  mgmtPhyAddr = 5'h01, mgmtRegAddr = 5'h00;
	logic        mgmtWrite = 0, mgmtRead = 0;
	logic [15:0] mgmtWrData = 16'h0000, mgmtRdData;
	logic        duplexStrap = 1, autoCrossoverStrap = 1;
	logic        indicatorModeSelect = 1;
	logic [4:0]  stationAddressStraps = 5'h01, stationAddr;
	logic        negOn = 0, autoXOn = 0, linkOn = 0, fastOn = 0;
	logic        busyOn = 0;
	logic [3:0]  abilSet = 4'h0, partnerAbil, loopSel;
	logic        partnerCanNeg, partnerAutoX, detSpeed100, mediaLinkUp;
	logic        randomBit, activity, mgmtRdValid, macTxAccept, macOutEn;
	logic        mediaSendData, mediaSendIdle, loopMac, linkReported;
	logic        crossover, speed100, fullDuplex, linkIndicatorOutput;
	logic [15:0] expq[$];
	logic [15:0] v;
	int          miscompares = 0, cmp_count = 0, t0, t1;

	pmc_top #(.HALF_CYC(8)) i_pmc_top (.ref_clk, .rst_b, .clkEn,
		.mgmtPhyAddr, .mgmtRegAddr, .mgmtWrite, .mgmtRead, .mgmtWrData,
		.mgmtRdData, .mgmtRdValid, .duplexStrap, .autoCrossoverStrap,
		.indicatorModeSelect, .stationAddressStraps, .partnerCanNeg,
		.partnerAbil, .partnerAutoX, .detSpeed100, .mediaLinkUp, .randomBit,
		.activity, .macTxEn, .macTxAccept, .macOutEn, .mediaSendData,
		.mediaSendIdle, .loopMac, .loopSel, .linkReported, .crossover,
		.speed100, .fullDuplex, .linkIndicatorOutput, .stationAddr);

	pmc_link_partner i_pmc_link_partner (.ref_clk, .negOn, .abilSet,
		.autoXOn, .linkOn, .fastOn, .busyOn, .partnerCanNeg, .partnerAbil,
		.partnerAutoX, .detSpeed100, .mediaLinkUp, .randomBit, .activity);

	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end

	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask : cyc

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		mgmtRegAddr = a;
		mgmtWrData = d;
		mgmtWrite = 1;
		cyc(1);
		mgmtWrite = 0;
		cyc(2);
	endtask : wr

	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		mgmtRegAddr = a;
		mgmtRead = 1;
		expq.push_back(e);
		cyc(1);
		mgmtRead = 0;
		cyc(1);
	endtask : rd

	// pickInd selects the indicator, else the crossover output
	task automatic toggles(input bit pickInd, input int n, output int t);
		logic p;
		logic c;
		t = 0;
		p = pickInd ? linkIndicatorOutput : crossover;
		repeat (n) begin
			cyc(1);
			c = pickInd ? linkIndicatorOutput : crossover;
			if (c !== p) t++;
			p = c;
		end
	endtask : toggles

	// straps flip after the latch edge to show they were captured
	task automatic rst(input logic [2:0] s, input logic [4:0] a);
		rst_b = 0;
		{duplexStrap, autoCrossoverStrap, indicatorModeSelect} = s;
		stationAddressStraps = a;
		cyc(2);
		rst_b = 1;
		cyc(1);
		{duplexStrap, autoCrossoverStrap, indicatorModeSelect} = ~s;
		stationAddressStraps = ~a;
		mgmtPhyAddr = a;
		cyc(1);
	endtask : rst

	task complete_run;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run

	// ------------------------------------------------------------------
	// read monitor: oldest expected value against each returned word
	// ------------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (rst_b && mgmtRdValid === 1'b1) begin
			if (expq.size() == 0) begin
				miscompares++;
				$display("mismatch at %0t: read data with none pending", $time);
			end else
				check(mgmtRdData, expq.pop_front());
		end
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		complete_run();
	end

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		v = 16'($urandom(24));
		rst(3'b111, 5'h01);
		check(stationAddr, 16'h0001);
		rd(REG_BASIC_MODE_CONTROL, BMC_RESET);
		rd(REG_AUTONEG_ADVERTISEMENT, 16'h01e1);
		rd(REG_CONTROL_ONE, 16'h4000);
		rd(REG_SELFTEST_LOOP_CONTROL, 16'h0000);
		rd(REG_INDICATOR_CONTROL, 16'h0000);
		rd(REG_PHY_CONTROL, 16'h8020);
		rd(5'h05, 16'h0000);
		mgmtPhyAddr = 5'h02;
		mgmtRead = 1;
		cyc(1);
		mgmtRead = 0;
		cyc(2);
		mgmtPhyAddr = 5'h01;
		negOn = 1;
		linkOn = 1;
		for (int a = 1; a < 16; a++) begin
			abilSet = a[3:0];
			cyc(3);
			check(speed100, 16'(a >= 4));
			check(fullDuplex, 16'(a[3] || (a < 4 && a[1])));
		end
		negOn = 0;
		for (int s = 0; s < 2; s++) begin
			fastOn = s[0];
			cyc(3);
			check(speed100, 16'(s));
			check(fullDuplex, 16'h0000);
		end
		wr(REG_BASIC_MODE_CONTROL, 16'h0100);
		check({speed100, fullDuplex}, 16'h0001);
		negOn = 1;
		macTxEn = 1;
		wr(REG_BASIC_MODE_CONTROL, 16'h1400);
		check({macOutEn, macTxAccept}, 16'h0000);
		check({mediaSendData, mediaSendIdle}, 16'h0001);
		check({linkReported, speed100, fullDuplex}, 16'h0007);
		rd(REG_BASIC_MODE_CONTROL, 16'h1400);
		wr(REG_BASIC_MODE_CONTROL, 16'h1000);
		check({macOutEn, macTxAccept}, 16'h0003);
		for (int b = 0; b < 4; b++) begin
			wr(REG_SELFTEST_LOOP_CONTROL, 16'h0001 << b);
			check(loopSel, 16'h0001 << b);
		end
		v = v & 16'h004f;
		wr(REG_SELFTEST_LOOP_CONTROL, v);
		rd(REG_SELFTEST_LOOP_CONTROL, v);
		check(loopSel, v & 16'h000f);
		wr(REG_SELFTEST_LOOP_CONTROL, 16'h0040);
		wr(REG_BASIC_MODE_CONTROL, 16'h6100);
		check({loopMac, linkReported, mediaSendData}, 16'h0005);
		wr(REG_BASIC_MODE_CONTROL, 16'h2100);
		wr(REG_SELFTEST_LOOP_CONTROL, 16'h0000);
		check({loopMac, loopSel, linkReported}, 16'h0001);
		linkOn = 0;
		wr(REG_CONTROL_ONE, 16'h0000);
		toggles(1'b0, 8, t0);
		check(16'(t0), 16'h0000);
		wr(REG_CONTROL_ONE, 16'h4000);
		toggles(1'b0, 8, t0);
		check(16'(t0 > 4), 16'h0001);
		autoXOn = 1;
		toggles(1'b0, 16, t0);
		check(16'(t0 > 0), 16'h0001);
		wr(REG_PHY_CONTROL, 16'h4020);
		check(crossover, 16'h0001);
		wr(REG_PHY_CONTROL, 16'h0020);
		check(crossover, 16'h0000);
		linkOn = 1;
		busyOn = 1;
		cyc(3);
		toggles(1'b1, 40, t0);
		check({15'(t0), linkIndicatorOutput}, 16'h0001);
		wr(REG_PHY_CONTROL, 16'h0000);
		rd(REG_PHY_CONTROL, 16'h0000);
		toggles(1'b1, 64, t0);
		wr(REG_INDICATOR_CONTROL, 16'h0200);
		toggles(1'b1, 64, t1);
		check(16'(t0 > 4), 16'h0001);
		check(16'(t1 > t0 + 4), 16'h0001);
		linkOn = 0;
		cyc(3);
		check(linkIndicatorOutput, 16'h0000);
		rst(3'b000, 5'h13);
		check(stationAddr, 16'h0013);
		rd(REG_AUTONEG_ADVERTISEMENT, 16'h00a1);
		rd(REG_CONTROL_ONE, 16'h0000);
		rd(REG_PHY_CONTROL, 16'h0000);
		linkOn = 1;
		abilSet = 4'hf;
		cyc(3);
		check({speed100, fullDuplex}, 16'h0002);
		wr(REG_BASIC_MODE_CONTROL, 16'h2100);
		check({speed100, fullDuplex}, 16'h0002);
		// clock enable low: a write must not land
		clkEn = 0;
		wr(REG_BASIC_MODE_CONTROL, 16'h0000);
		clkEn = 1;
		rd(REG_BASIC_MODE_CONTROL, 16'h2100);
		check({speed100, fullDuplex}, 16'h0002);
		cyc(4);
		check(16'(expq.size()), 16'h0000);
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
